/* can_sfr_consts.svh */
// Constants of the CAN byte-register bank: page, addresses, reset values.
// Assumes the including file sits in the same folder.
`ifndef CAN_SFR_CONSTS_SVH
`define CAN_SFR_CONSTS_SVH
// ****************************************
// Page and clock configuration
// ****************************************
`define CAN_PAGE 8'h0c
`define SADR_CFG 8'h92
`define CFG_RESET 2'h0
// ****************************************
// Byte addresses of the low halves
// ****************************************
`define SADR_CTRL 8'hc0
`define SADR_STAT 8'h94
`define SADR_ERR 8'h96
`define SADR_BT 8'h9a
`define SADR_IID 8'h9c
`define SADR_TST 8'h9e
`define SADR_BRPE 8'ha1
`define SADR_A_CR 8'hbe
`define SADR_A_CM 8'hc2
`define SADR_A_M1 8'hc4
`define SADR_A_M2 8'hc6
`define SADR_A_A1 8'hca
`define SADR_A_A2 8'hcc
`define SADR_A_MC 8'hd2
`define SADR_A_DA1 8'hd4
`define SADR_A_DA2 8'hd6
`define SADR_A_DB1 8'hda
`define SADR_A_DB2 8'hdc
`define SADR_B_CR 8'hde
`define SADR_B_CM 8'he2
`define SADR_B_M1 8'hea
`define SADR_B_M2 8'hec
`define SADR_B_A1 8'hee
`define SADR_B_A2 8'hf2
`define SADR_B_MC 8'hce
`define SADR_B_DA1 8'hf6
`define SADR_B_DA2 8'hfa
`define SADR_B_DB1 8'hfc
`define SADR_B_DB2 8'hfe
`define SADR_TR1 8'ha2
`define SADR_TR2 8'ha4
`define SADR_ND1 8'haa
`define SADR_ND2 8'hac
`define SADR_IP1 8'hae
`define SADR_IP2 8'hb2
`define SADR_MV1 8'hba
`define SADR_MV2 8'hbc
// ****************************************
// Core word addresses
// ****************************************
`define CADR_CTRL 8'h00
`define CADR_STAT 8'h02
`define CADR_ERR 8'h04
`define CADR_BT 8'h06
`define CADR_IID 8'h08
`define CADR_TST 8'h0a
`define CADR_BRPE 8'h0c
`define CADR_A_CR 8'h10
`define CADR_A_CM 8'h12
`define CADR_A_M1 8'h14
`define CADR_A_M2 8'h16
`define CADR_A_A1 8'h18
`define CADR_A_A2 8'h1a
`define CADR_A_MC 8'h1c
`define CADR_A_DA1 8'h1e
`define CADR_A_DA2 8'h20
`define CADR_A_DB1 8'h22
`define CADR_A_DB2 8'h24
`define CADR_B_CR 8'h40
`define CADR_B_CM 8'h42
`define CADR_B_M1 8'h44
`define CADR_B_M2 8'h46
`define CADR_B_A1 8'h48
`define CADR_B_A2 8'h4a
`define CADR_B_MC 8'h4c
`define CADR_B_DA1 8'h4e
`define CADR_B_DA2 8'h50
`define CADR_B_DB1 8'h52
`define CADR_B_DB2 8'h54
`define CADR_TR1 8'h80
`define CADR_TR2 8'h82
`define CADR_ND1 8'h90
`define CADR_ND2 8'h92
`define CADR_IP1 8'ha0
`define CADR_IP2 8'ha2
`define CADR_MV1 8'hb0
`define CADR_MV2 8'hb2
// ****************************************
// Reset values and control bits
// ****************************************
`define RST_CTRL 16'h0001
`define RST_BT 16'h2301
`define RST_CR 16'h0001
`define RST_MASK 16'hffff
`define CTRL_CFG_CHANGE_BIT 6
`define CTRL_TEST_BIT 7
`define TST_RX_BIT 7
`endif

/* can_sfr_pkg.sv */
// Types shared by the CAN byte-register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package can_sfr_pkg;
	// Result of decoding one byte address
	typedef struct packed {
		logic       hit;      // Address belongs to the bank
		logic       cfg;      // Clock configuration byte
		logic       ro;       // Word is core state, read only
		logic       wide;     // Word has a high byte
		logic       hi;       // Access is to the high byte
		logic [7:0] can_addr; // Core word address
	} decode_type;
	// Where a pending read takes its byte from
	typedef enum logic [3:0] {
		SRC_LOCAL = 4'b0001,
		SRC_CFG   = 4'b0010,
		SRC_TST   = 4'b0100,
		SRC_CORE  = 4'b1000
	} read_source_type;
endpackage : can_sfr_pkg

/* can_clock_divider.sv */
// Divider that gives the CAN controller clock as a tick on the system clock.
// Assumes select comes from a register on the same clock.
module can_clock_divider
(
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       clock_enable,
	input  wire logic [1:0] clock_divide_select,
	output logic            can_clock_tick
);
	logic [2:0] count;      // Cycles since last tick
	logic [2:0] next_count;
	logic       next_tick;
	logic [2:0] last;       // Terminal count for the chosen ratio

	// ****************************************
	// Divide by 1, 2, 4 or 8
	// ****************************************
	// Next count and tick
	always_comb
	begin
		last = 3'((4'h1 << clock_divide_select) - 4'h1);
		if (count >= last)
		begin
			next_count = 3'h0;
			next_tick  = 1'b1;
		end
		else
		begin
			next_count = count + 3'h1;
			next_tick  = 1'b0;
		end
	end

	// Registers, frozen while enable is low
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count          <= 3'h0;
			can_clock_tick <= 1'b0;
		end
		else if (clock_enable)
		begin
			count          <= next_count;
			can_clock_tick <= next_tick;
		end
	end

	// Divide by one ticks every enabled cycle
	div_one_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_enable && clock_divide_select == 2'h0 |=> can_clock_tick)
		else $error("divide by one did not tick");
	// Divide by eight does not tick on the second cycle after a tick
	div_eight_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_divide_select == 2'h3 && $stable(clock_divide_select) && can_clock_tick
		&& count == 3'h0 ##1 clock_enable && clock_divide_select == 2'h3 |=> !can_clock_tick)
		else $error("divide by eight ticked too soon");
endmodule : can_clock_divider

/* can_sfr_register_map.sv */
// Byte-wide register bank that carries the CAN core's word registers.
// Assumes the byte bus and the core run on clock; the receive pin does not.
//
// What this block does
// - Decode bank only on its own page
// - Divider codes give clock over 1,2,4,8
// - Divider register upper six bits read zero
// - ERR, IID and the TR, ND, IP, MV words are read only core state; STAT is stored locally
// - Timing and prescaler writes need config enable
// - Test register writable only in test mode
// - Reset loads the documented word values
// - Each word but CTRL, STAT, TST and BRPE is a low/high byte pair
// - Extra clock configuration byte, resets zero
// - Command request low-byte write starts object transfer
module can_sfr_register_map
	import can_sfr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        clock_enable,
	input  wire logic [7:0]  sfr_page,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_write,
	input  wire logic        sfr_read,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_rvalid,
	input  wire logic        can_rx_pin,
	input  wire logic [15:0] core_rdata,
	output logic      [7:0]  core_raddr,
	output logic             core_write,
	output logic      [7:0]  core_waddr,
	output logic      [15:0] core_wdata,
	output logic             start_transfer_a,
	output logic             start_transfer_b,
	output logic             can_clock_tick
);
`include "can_sfr_consts.svh"

	// ****************************************
	// Helper functions
	// ****************************************
	// Core word address to storage slot
	function automatic logic [5:0] widx(input logic [7:0] a);
		widx = {a[6], a[5:1]};
	endfunction : widx

	// Match a low byte address
	function automatic decode_type lookup(input logic [7:0] a);
		decode_type d;
		d = '0;
		d.hit = 1'b1;
		d.wide = 1'b1;
		case (a)
			`SADR_CTRL: {d.wide, d.can_addr} = {1'b0, `CADR_CTRL};
			`SADR_STAT: {d.wide, d.can_addr} = {1'b0, `CADR_STAT};
			`SADR_TST: {d.wide, d.can_addr} = {1'b0, `CADR_TST};
			`SADR_BRPE: {d.wide, d.can_addr} = {1'b0, `CADR_BRPE};
			`SADR_ERR: d.can_addr = `CADR_ERR;
			`SADR_BT: d.can_addr = `CADR_BT;
			`SADR_IID: d.can_addr = `CADR_IID;
			`SADR_A_CR: d.can_addr = `CADR_A_CR;
			`SADR_A_CM: d.can_addr = `CADR_A_CM;
			`SADR_A_M1: d.can_addr = `CADR_A_M1;
			`SADR_A_M2: d.can_addr = `CADR_A_M2;
			`SADR_A_A1: d.can_addr = `CADR_A_A1;
			`SADR_A_A2: d.can_addr = `CADR_A_A2;
			`SADR_A_MC: d.can_addr = `CADR_A_MC;
			`SADR_A_DA1: d.can_addr = `CADR_A_DA1;
			`SADR_A_DA2: d.can_addr = `CADR_A_DA2;
			`SADR_A_DB1: d.can_addr = `CADR_A_DB1;
			`SADR_A_DB2: d.can_addr = `CADR_A_DB2;
			`SADR_B_CR: d.can_addr = `CADR_B_CR;
			`SADR_B_CM: d.can_addr = `CADR_B_CM;
			`SADR_B_M1: d.can_addr = `CADR_B_M1;
			`SADR_B_M2: d.can_addr = `CADR_B_M2;
			`SADR_B_A1: d.can_addr = `CADR_B_A1;
			`SADR_B_A2: d.can_addr = `CADR_B_A2;
			`SADR_B_MC: d.can_addr = `CADR_B_MC;
			`SADR_B_DA1: d.can_addr = `CADR_B_DA1;
			`SADR_B_DA2: d.can_addr = `CADR_B_DA2;
			`SADR_B_DB1: d.can_addr = `CADR_B_DB1;
			`SADR_B_DB2: d.can_addr = `CADR_B_DB2;
			`SADR_TR1: d.can_addr = `CADR_TR1;
			`SADR_TR2: d.can_addr = `CADR_TR2;
			`SADR_ND1: d.can_addr = `CADR_ND1;
			`SADR_ND2: d.can_addr = `CADR_ND2;
			`SADR_IP1: d.can_addr = `CADR_IP1;
			`SADR_IP2: d.can_addr = `CADR_IP2;
			`SADR_MV1: d.can_addr = `CADR_MV1;
			`SADR_MV2: d.can_addr = `CADR_MV2;
			default: d = '0;
		endcase
		lookup = d;
	endfunction : lookup

	// Full decode: low byte, else high byte of a wide word
	function automatic decode_type decode(input logic [7:0] a);
		decode_type d;
		d = lookup(a);
		if (!d.hit)
		begin
			d = lookup(a - 8'h01);
			d.hit = d.hit && d.wide;
			d.hi = 1'b1;
		end
		if (a == `SADR_CFG)
		begin
			d = '0;
			d.hit = 1'b1;
			d.cfg = 1'b1;
		end
		d.ro = d.hit && !d.cfg && (d.can_addr == `CADR_ERR
			|| d.can_addr == `CADR_IID || d.can_addr[7]);
		decode = d;
	endfunction : decode

	// Reset value of a storage slot
	function automatic logic [15:0] reset_word(input logic [5:0] i);
		case (i)
			widx(`CADR_CTRL): reset_word = `RST_CTRL;
			widx(`CADR_BT): reset_word = `RST_BT;
			widx(`CADR_A_CR), widx(`CADR_B_CR): reset_word = `RST_CR;
			widx(`CADR_A_M1), widx(`CADR_A_M2): reset_word = `RST_MASK;
			widx(`CADR_B_M1), widx(`CADR_B_M2): reset_word = `RST_MASK;
			default: reset_word = 16'h0000;
		endcase
	endfunction : reset_word

	// Byte of a word
	function automatic logic [7:0] pick(input logic [15:0] w, input logic hi);
		pick = hi ? w[15:8] : w[7:0];
	endfunction : pick

	// ****************************************
	// Decode and storage
	// ****************************************
	logic [15:0] words [0:63];      // Writable core words
	logic [15:0] next_words [0:63];
	logic [1:0]  div_sel;           // Clock divide select
	logic [1:0]  next_div_sel;
	decode_type  dec;               // Current access decode
	logic [5:0]  idx;               // Slot of current access
	logic        sel_hit;           // Access on our page and mapped
	logic        config_change_enable; // Config change enable
	logic        test_en;           // Test mode enable
	logic        locked;            // Word refuses writes now
	logic        rx_meta;           // Receive pin first stage
	logic        rx_sync;           // Receive pin, synchronised
	logic        next_core_write;
	logic [7:0]  next_core_waddr;
	logic [15:0] next_core_wdata;
	logic        next_start_a;
	logic        next_start_b;

	assign dec     = decode(sfr_addr);
	assign idx     = widx(dec.can_addr);
	assign sel_hit = (sfr_page == `CAN_PAGE) && dec.hit;
	assign config_change_enable = words[widx(`CADR_CTRL)][`CTRL_CFG_CHANGE_BIT];
	assign test_en = words[widx(`CADR_CTRL)][`CTRL_TEST_BIT];
	assign locked  = ((idx == widx(`CADR_BT) || idx == widx(`CADR_BRPE))
		&& !config_change_enable)
		|| (idx == widx(`CADR_TST) && !test_en);

	// ****************************************
	// Write path
	// ****************************************
	// Next storage, mirror write and transfer starts
	always_comb
	begin
		logic [15:0] merged;
		merged          = words[idx];
		next_words      = words;
		next_div_sel    = div_sel;
		next_core_write = 1'b0;
		next_core_waddr = core_waddr;
		next_core_wdata = core_wdata;
		next_start_a    = 1'b0;
		next_start_b    = 1'b0;
		if (sfr_write && sel_hit)
		begin
			if (dec.cfg)
				next_div_sel = sfr_wdata[1:0];
			else if (!dec.ro && !locked)
			begin
				// Byte lands in its half of the word
				if (dec.hi)
					merged[15:8] = sfr_wdata;
				else
					merged[7:0] = sfr_wdata;
				next_words[idx] = merged;
				next_core_write = 1'b1;
				next_core_waddr = dec.can_addr;
				next_core_wdata = merged;
				// Object number written into a request word
				next_start_a = (dec.can_addr == `CADR_A_CR) && !dec.hi;
				next_start_b = (dec.can_addr == `CADR_B_CR) && !dec.hi;
			end
		end
	end

	// Storage registers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < 64; i++)
				words[i] <= reset_word(6'(i));
			div_sel          <= `CFG_RESET;
			core_write       <= 1'b0;
			core_waddr       <= 8'h00;
			core_wdata       <= 16'h0000;
			start_transfer_a <= 1'b0;
			start_transfer_b <= 1'b0;
		end
		else if (clock_enable)
		begin
			words            <= next_words;
			div_sel          <= next_div_sel;
			core_write       <= next_core_write;
			core_waddr       <= next_core_waddr;
			core_wdata       <= next_core_wdata;
			start_transfer_a <= next_start_a;
			start_transfer_b <= next_start_b;
		end
	end

	// ****************************************
	// Receive pin synchroniser
	// ****************************************
	logic next_rx_meta;
	logic next_rx_sync;

	// Two stages before use
	always_comb
	begin
		next_rx_meta = can_rx_pin;
		next_rx_sync = rx_meta;
	end

	// Synchroniser registers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end
		else if (clock_enable)
		begin
			rx_meta <= next_rx_meta;
			rx_sync <= next_rx_sync;
		end
	end

	// ****************************************
	// Read path, answer two edges after request
	// ****************************************
	logic            rd_pend;      // Read waiting for its data
	logic            next_rd_pend;
	read_source_type rd_src;       // Source of pending read
	read_source_type next_rd_src;
	logic            rd_hi;        // Pending read wants high byte
	logic            next_rd_hi;
	logic [5:0]      rd_idx;       // Slot of pending read
	logic [5:0]      next_rd_idx;
	logic [7:0]      next_core_raddr;
	logic [7:0]      next_rdata;
	logic            next_rvalid;

	// Capture request, then select the byte
	always_comb
	begin
		next_rd_pend    = sfr_read && sel_hit;
		next_rd_src     = rd_src;
		next_rd_hi      = rd_hi;
		next_rd_idx     = rd_idx;
		next_core_raddr = core_raddr;
		if (next_rd_pend)
		begin
			next_rd_hi      = dec.hi;
			next_rd_idx     = idx;
			next_core_raddr = dec.can_addr;
			if (dec.cfg)
				next_rd_src = SRC_CFG;
			else if (dec.ro)
				next_rd_src = SRC_CORE;
			else if (idx == widx(`CADR_TST))
				next_rd_src = SRC_TST;
			else
				next_rd_src = SRC_LOCAL;
		end
		next_rvalid = rd_pend;
		next_rdata  = sfr_rdata;
		if (rd_pend)
		begin
			case (rd_src)
				SRC_CFG: next_rdata = {6'h00, div_sel};
				SRC_CORE: next_rdata = pick(core_rdata, rd_hi);
				SRC_TST: next_rdata = {rx_sync, words[rd_idx][6:0]};
				SRC_LOCAL: next_rdata = pick(words[rd_idx], rd_hi);
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Read registers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_pend    <= 1'b0;
			rd_src     <= SRC_LOCAL;
			rd_hi      <= 1'b0;
			rd_idx     <= 6'h00;
			core_raddr <= 8'h00;
			sfr_rdata  <= 8'h00;
			sfr_rvalid <= 1'b0;
		end
		else if (clock_enable)
		begin
			rd_pend    <= next_rd_pend;
			rd_src     <= next_rd_src;
			rd_hi      <= next_rd_hi;
			rd_idx     <= next_rd_idx;
			core_raddr <= next_core_raddr;
			sfr_rdata  <= next_rdata;
			sfr_rvalid <= next_rvalid;
		end
	end

	// ****************************************
	// Controller clock divider
	// ****************************************
	can_clock_divider can_clock_divider_i
	(
		.clock               (clock),
		.reset_n             (reset_n),
		.clock_enable        (clock_enable),
		.clock_divide_select (div_sel),
		.can_clock_tick      (can_clock_tick)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	other_page_a: assert property (
		clock_enable && sfr_write && sfr_page != `CAN_PAGE |=> !core_write)
		else $error("write on foreign page reached core");
	cfg_upper_a: assert property (
		clock_enable && sfr_read && sfr_page == `CAN_PAGE && sfr_addr == `SADR_CFG
		##1 clock_enable |=> sfr_rvalid && sfr_rdata[7:2] == 6'h00)
		else $error("divider register upper bits not zero");
	core_read_a: assert property (
		clock_enable && sfr_read && sel_hit && dec.ro ##1 clock_enable
		|=> sfr_rvalid && sfr_rdata == pick($past(core_rdata), $past(dec.hi, 2)))
		else $error("read-only byte not from core");
	timing_lock_a: assert property (
		clock_enable && sfr_write && sel_hit && dec.can_addr == `CADR_BT
		&& !config_change_enable
		|=> !core_write && $stable(words[widx(`CADR_BT)]))
		else $error("timing word written without config enable");
	test_lock_a: assert property (
		clock_enable && sfr_write && sel_hit && idx == widx(`CADR_TST) && !dec.cfg
		&& !test_en |=> !core_write)
		else $error("test register written outside test mode");
	reset_vals_a: assert property (
		$rose(reset_n) |-> words[widx(`CADR_BT)] == `RST_BT
		&& words[widx(`CADR_A_M1)] == `RST_MASK && words[widx(`CADR_B_CR)] == `RST_CR)
		else $error("wrong reset value");
	high_byte_a: assert property (
		clock_enable && sfr_write && sel_hit && dec.hi && !dec.ro && !locked
		|=> core_write && core_wdata[15:8] == $past(sfr_wdata))
		else $error("high byte not merged into word");
	start_a_a: assert property (
		clock_enable && sfr_write && sfr_page == `CAN_PAGE && sfr_addr == `SADR_A_CR
		|=> start_transfer_a && core_waddr == `CADR_A_CR)
		else $error("request write did not start transfer");
	ro_drop_a: assert property (
		clock_enable && sfr_write && sel_hit && dec.ro |=> !core_write && !start_transfer_b)
		else $error("read-only write had an effect");

	cfg_write_c: cover property (clock_enable && sfr_write && sel_hit && dec.cfg);
	start_b_c: cover property (start_transfer_b);
	core_read_c: cover property (sfr_rvalid && rd_src == SRC_CORE);
endmodule : can_sfr_register_map

/* core_model.sv */
// Behavioural model of the CAN core's register port.
// Assumes the bank samples core_rdata on the same clock.
module core_model
(
	input  wire logic [7:0]  core_raddr,
	input  wire logic        core_write,
	input  wire logic [7:0]  core_waddr,
	input  wire logic [15:0] core_wdata,
	output logic      [15:0] core_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Core state
	// ****************************************
	// Status words differ per address and per byte half
	assign core_rdata = {~core_raddr, core_raddr};
endmodule : core_model

/* test_can_sfr_register_map.sv */
// Self-checking bench for the CAN byte-register bank.
// Assumes the header and package of the bank in the same folder.
`include "can_sfr_consts.svh"
module test_can_sfr_register_map;
	timeunit 1ns;
	timeprecision 1ns;
	import can_sfr_pkg::*;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  sfr_page = 8'h00;
	logic [7:0]  sfr_addr = 8'h00;
	logic [7:0]  sfr_wdata = 8'h00;
	logic        sfr_write = 1'b0;
	logic        sfr_read = 1'b0;
	logic        can_rx_pin = 1'b1;
	logic        clock_enable = 1'b1;
	logic [7:0]  sfr_rdata, core_raddr, core_waddr;
	logic [15:0] core_rdata, core_wdata;
	logic        sfr_rvalid, core_write, start_transfer_a, start_transfer_b;
	logic        can_clock_tick;
	logic        cw, sa, sb, last_wr = 1'b0;
	logic [7:0]  wa;
	logic [15:0] wd;
	int          failures = 0;
	int          samples_checked = 0;
	int          cnt;
	// Reset table and read-only table
	logic [7:0]  ra [15] = '{`SADR_CTRL, `SADR_STAT, `SADR_BT, `SADR_BT + 8'h01,
		`SADR_A_CR, `SADR_A_CR + 8'h01, `SADR_B_CR, `SADR_A_M1, `SADR_A_M2 + 8'h01,
		`SADR_B_M1, `SADR_B_M2 + 8'h01, `SADR_B_DB2 + 8'h01, `SADR_CFG, `SADR_BRPE,
		`SADR_TST};
	logic [7:0]  rv [15] = '{8'h01, 8'h00, 8'h01, 8'h23, 8'h01, 8'h00, 8'h01,
		8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h80};
	logic [7:0]  os [10] = '{`SADR_ERR, `SADR_IID, `SADR_TR1, `SADR_TR2, `SADR_ND1,
		`SADR_ND2, `SADR_IP1, `SADR_IP2, `SADR_MV1, `SADR_MV2};
	logic [7:0]  oc [10] = '{`CADR_ERR, `CADR_IID, `CADR_TR1, `CADR_TR2, `CADR_ND1,
		`CADR_ND2, `CADR_IP1, `CADR_IP2, `CADR_MV1, `CADR_MV2};
	// 25 MHz system clock keeps the controller clock legal at every divide
	always #20 clock = ~clock;
	// ****************************************
	// Design and core model
	// ****************************************
	can_sfr_register_map can_sfr_register_map_i (.clock(clock), .reset_n(reset_n),
		.clock_enable(clock_enable), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
		.sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .can_rx_pin(can_rx_pin),
		.core_rdata(core_rdata), .core_raddr(core_raddr), .core_write(core_write),
		.core_waddr(core_waddr), .core_wdata(core_wdata),
		.start_transfer_a(start_transfer_a), .start_transfer_b(start_transfer_b),
		.can_clock_tick(can_clock_tick));
	core_model core_model_i (.core_raddr(core_raddr), .core_write(core_write),
		.core_waddr(core_waddr), .core_wdata(core_wdata), .core_rdata(core_rdata));
	// ****************************************
	// Bus tasks
	// ****************************************
	// Value compare, counts every call
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Byte write, captures the core side one edge later
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (last_wr)
			@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_write = 1'b1;
		@(negedge clock);
		sfr_write = 1'b0;
		last_wr = 1'b1;
		cw = core_write;
		sa = start_transfer_a;
		sb = start_transfer_b;
		wa = core_waddr;
		wd = core_wdata;
	endtask : wr
	// Byte read with bounded wait for the valid pulse
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int n;
		sfr_addr = a;
		sfr_read = 1'b1;
		last_wr = 1'b0;
		@(negedge clock);
		sfr_read = 1'b0;
		ok = 1'b0;
		d = 8'h00;
		for (n = 0; n < 4 && ok !== 1'b1; n++)
		begin
			@(negedge clock);
			if (sfr_rvalid === 1'b1)
			begin
				ok = 1'b1;
				d = sfr_rdata;
			end
		end
	endtask : rd
	// Read and compare one byte
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		rd(a, d, ok);
		check("rvalid", 16'h0001, {15'h0, ok});
		check("rdata", {8'h00, e}, {8'h00, d});
	endtask : rc
	// Counts and verdict
	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		logic [7:0] d;
		logic       ok;
		repeat (20) @(negedge clock);
		reset_n = 1'b1;
		@(negedge clock);
		sfr_page = `CAN_PAGE;
		// Reset values, divider byte included
		for (int i = 0; i < 15; i++)
			rc(ra[i], rv[i]);
		// Another page: no answer, no write
		sfr_page = 8'h0b;
		rd(`SADR_CTRL, d, ok);
		check("page read", 16'h0000, {15'h0, ok});
		wr(`SADR_A_M1, 8'h00);
		check("page write", 16'h0000, {15'h0, cw});
		sfr_page = `CAN_PAGE;
		rc(`SADR_A_M1, 8'hff);
		// Frozen state: a write while enable is low is not taken
		clock_enable = 1'b0;
		wr(`SADR_A_M1, 8'h00);
		check("frozen write", 16'h0000, {15'h0, cw});
		clock_enable = 1'b1;
		rc(`SADR_A_M1, 8'hff);
		// Every divide code, upper bits ignored
		for (int c = 0; c < 4; c++)
		begin
			wr(`SADR_CFG, {6'h3f, c[1:0]});
			repeat (7) @(negedge clock);
			rc(`SADR_CFG, {6'h00, c[1:0]});
			repeat (16) @(negedge clock);
			cnt = 0;
			repeat (32)
			begin
				@(negedge clock);
				if (can_clock_tick === 1'b1)
					cnt++;
			end
			check("ticks", 16'(32 >> c), 16'(cnt));
		end
		wr(`SADR_CFG, 8'h00);
		// Timing words locked until config enable
		wr(`SADR_BT, 8'h55);
		check("bt locked", 16'h0000, {15'h0, cw});
		wr(`SADR_BRPE, 8'h0f);
		rc(`SADR_BT, 8'h01);
		rc(`SADR_BRPE, 8'h00);
		wr(`SADR_CTRL, 8'h41);
		wr(`SADR_BT, 8'h55);
		check("bt write", 16'h0001, {15'h0, cw});
		check("bt addr", {8'h00, `CADR_BT}, {8'h00, wa});
		check("bt word", 16'h2355, wd);
		wr(`SADR_BRPE, 8'h0f);
		rc(`SADR_BRPE, 8'h0f);
		// Test word locked until test enable
		wr(`SADR_TST, 8'h2a);
		rc(`SADR_TST, 8'h80);
		wr(`SADR_CTRL, 8'h81);
		can_rx_pin = 1'b0;
		wr(`SADR_TST, 8'h2a);
		wr(`SADR_BT, 8'h77);
		repeat (3) @(negedge clock);
		rc(`SADR_TST, 8'h2a);
		rc(`SADR_BT, 8'h55);
		// Read-only words: core state, writes dropped
		for (int i = 0; i < 10; i++)
		begin
			wr(os[i], 8'h12);
			check("ro write", 16'h0000, {15'h0, cw});
			rc(os[i], oc[i]);
			rc(os[i] + 8'h01, ~oc[i]);
		end
		// Request words start transfers on the low byte
		wr(`SADR_A_CR, 8'h05);
		check("start a", 16'h0006, {13'h0, cw, sa, sb});
		check("cr addr", {8'h00, `CADR_A_CR}, {8'h00, wa});
		check("cr word", 16'h0005, wd);
		wr(`SADR_A_CR + 8'h01, 8'h80);
		check("cr high", 16'h0004, {13'h0, cw, sa, sb});
		check("cr word", 16'h8005, wd);
		wr(`SADR_B_CR, 8'h07);
		check("start b", 16'h0005, {13'h0, cw, sa, sb});
		check("cr addr", {8'h00, `CADR_B_CR}, {8'h00, wa});
		// Read right after write returns the new byte
		wr(`SADR_A_DA1 + 8'h01, 8'hc3);
		rc(`SADR_A_DA1 + 8'h01, 8'hc3);
		rc(`SADR_A_CR + 8'h01, 8'h80);
		close_out();
	end
endmodule : test_can_sfr_register_map
